//--- core/ueb_map.vh
// register map, field positions and counts for the serial port block
// assumes a 32-bit classic wishbone bus with byte addresses
`ifndef UEB_MAP_VH
`define UEB_MAP_VH
// byte offsets
`define UEB_OFF_CTRL    8'h00
`define UEB_OFF_DATA    8'h04
`define UEB_OFF_STAT    8'h08
`define UEB_OFF_PWR     8'h0c
`define UEB_OFF_BAUD    8'h10
`define UEB_OFF_IRQ_ST  8'h14
`define UEB_OFF_IRQ_MSK 8'h18
`define UEB_OFF_RST_SRC 8'h1c
// serial_control_reg fields
`define UEB_CTRL_MODE_HI 7
`define UEB_CTRL_MODE_LO 6
`define UEB_CTRL_RX_EN   4
`define UEB_CTRL_TX_B8   3
`define UEB_CTRL_RX_B8   2
`define UEB_CTRL_TX_INT  1
`define UEB_CTRL_RX_INT  0
// serial_status_reg fields
`define UEB_STAT_DBUF    7
`define UEB_STAT_BRK_RST 6
`define UEB_STAT_TX_BUSY 4
`define UEB_STAT_FE      3
`define UEB_STAT_BRK     2
// power_control_reg field
`define UEB_PWR_FE_SEL   6
// interrupt status and mask fields
`define UEB_IRQ_RX       0
`define UEB_IRQ_TX       1
`define UEB_IRQ_FE       2
`define UEB_IRQ_BRK      3
`define UEB_IRQ_W        4
// reset values
`define UEB_BAUD_RST     16'h0040
`define UEB_CTRL_RST     8'h00
`define UEB_STAT_RST     8'h00
// timing counts in oversample ticks; break length also given in bit periods
`define UEB_OVS_LAST     4'hf
`define UEB_OVS_MID      4'h7
`define UEB_BRK_BITS     8'd11
`define UEB_BRK_TICKS    8'd176
`endif

//--- core/ueb_tx.v
// transmit shifter with optional one-character holding buffer
// assumes tick_i is a one-cycle pulse at sixteen times the bit rate
`include "ueb_map.vh"
module ueb_tx (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // control
    input  wire       tick_i,
    input  wire       load_i,
    input  wire [7:0] data_i,
    input  wire       ninth_i,
    input  wire       nine_i,
    input  wire       dbuf_i,
    // status
    output reg        txd_o,
    output reg        done_o,
    output reg        free_o,
    output reg        busy_o
);
    reg [9:0] sh_q;
    reg [3:0] bit_q;
    reg [3:0] sub_q;
    reg [8:0] hold_q;
    reg       hold_full_q;
    reg       fdb_q;
    wire [3:0] last_w;
    reg        txd_d;

    assign last_w = nine_i ? 4'd10 : 4'd9;

    // ninth bit read live when not buffered
    always @*
    begin
        txd_d = 1'b1;
        if (busy_o)
        begin
            if (bit_q == last_w)
                txd_d = 1'b1;
            else if (bit_q == 4'd9 && !fdb_q)
                txd_d = ninth_i;
            else
                txd_d = sh_q[0];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sh_q        <= 10'h3ff;
            bit_q       <= 4'h0;
            sub_q       <= 4'h0;
            hold_q      <= 9'h000;
            hold_full_q <= 1'b0;
            fdb_q       <= 1'b0;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            free_o      <= 1'b0;
            txd_o       <= 1'b1;
        end
        else
        begin
            txd_o  <= txd_d;
            done_o <= 1'b0;
            free_o <= 1'b0;
            if (busy_o && tick_i)
            begin
                sub_q <= sub_q + 4'h1;
                if (sub_q == `UEB_OVS_LAST)
                begin
                    if (bit_q == last_w)
                    begin
                        done_o <= 1'b1;
                        // back to back frames, one stop bit
                        if (hold_full_q)
                        begin
                            sh_q        <= {hold_q, 1'b0};
                            bit_q       <= 4'h0;
                            fdb_q       <= 1'b1;
                            hold_full_q <= 1'b0;
                            free_o      <= 1'b1;
                        end
                        else
                            busy_o <= 1'b0;
                    end
                    else
                    begin
                        bit_q <= bit_q + 4'h1;
                        sh_q  <= {1'b1, sh_q[9:1]};
                    end
                end
            end
            else if (!busy_o && hold_full_q)
            begin
                sh_q        <= {hold_q, 1'b0};
                bit_q       <= 4'h0;
                sub_q       <= 4'h0;
                fdb_q       <= 1'b1;
                busy_o      <= 1'b1;
                hold_full_q <= 1'b0;
                free_o      <= 1'b1;
            end
            // ninth bit latched with the data byte
            if (load_i && dbuf_i)
            begin
                hold_q      <= {ninth_i, data_i};
                hold_full_q <= 1'b1;
            end
            // conventional port: a write starts a frame at once
            if (load_i && !dbuf_i)
            begin
                sh_q   <= {ninth_i, data_i, 1'b0};
                bit_q  <= 4'h0;
                sub_q  <= 4'h0;
                fdb_q  <= 1'b0;
                busy_o <= 1'b1;
            end
        end
    end
endmodule

//--- core/ueb_top.v
// serial port with framing error, break detect and transmit double buffer
// assumes classic wishbone master on clk_i; rxd_i is asynchronous
// Functional notes
// - framing error always shows as a flag in the serial status register
// - with framing error select set, control bit 7 reads the error flag
// - eleven low bit periods on the receive line report a break flag
// - an enabled break resets the device and forces programming mode
// - after a break reset fetch starts at the boot address
// - double buffer holds next character; frames then share one stop bit
// - double buffer bit (status bit 7) clear gives a conventional single-buffered port
// - buffered transmit interrupt fires when the holding buffer frees
// - buffered, the ninth bit is latched with the data byte on write
// - eight-bit frames: start, eight data lsb first, stop into rx ninth
// - nine-bit frames: ninth bit to rx ninth bit, stop bit dropped
`include "ueb_map.vh"
module ueb_top (
    // clock and resets
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        por_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // serial line
    input  wire        rxd_i,
    output wire        txd_o,
    // system
    output reg         irq_o,
    output reg         device_reset_o,
    output wire        boot_from_vector_o,
    output wire        in_system_programming_mode_o
);
    localparam RX_IDLE  = 3'b001;
    localparam RX_START = 3'b010;
    localparam RX_DATA  = 3'b100;

    wire        sys_rst, req, wr, rd, ctrl_wr, stat_wr;
    wire        nine_w, tx_done, tx_free, tx_busy, tx_ev;
    wire [3:0]  rx_last_w;
    reg         rx_s1_q, rx_s2_q, tick_q, boot_q;
    reg         mode_hi_q, mode_lo_q, rx_en_q, tx_b8_q, rx_b8_q;
    reg         ti_q, ri_q, dbuf_q, brk_rst_q, fe_q, brk_q, fe_sel_q;
    reg         brk_arm_q, brk_ev_q, rx_done_q, rx_fe_q, rx_b8_new_q;
    reg  [15:0] baud_q, bcnt_q;
    reg  [7:0]  rx_data_q, rx_byte_q, brk_cnt_q;
    reg  [`UEB_IRQ_W-1:0] ist_q, imsk_q;
    reg  [2:0]  rx_st_q;
    reg  [3:0]  rx_sub_q, rx_bit_q;
    reg  [8:0]  rx_sh_q;
    reg  [31:0] rdat_d;

    assign sys_rst = rst_i | por_i;
    assign req     = cyc_i & stb_i;
    // effects happen at the edge where the master sees ack
    assign wr      = req & ack_o & we_i & sel_i[0];
    assign rd      = req & ack_o & ~we_i;
    assign ctrl_wr = wr && adr_i == `UEB_OFF_CTRL;
    assign stat_wr = wr && adr_i == `UEB_OFF_STAT;
    assign nine_w  = mode_hi_q;
    assign rx_last_w = nine_w ? 4'd9 : 4'd8;
    // buffered port raises tx interrupt on buffer free
    assign tx_ev   = dbuf_q ? tx_free : tx_done;
    assign boot_from_vector_o = boot_q;
    assign in_system_programming_mode_o = boot_q;

    // unmapped reads return zero
    always @*
    begin
        rdat_d = 32'h00000000;
        case (adr_i)
            `UEB_OFF_CTRL:
                rdat_d[7:0] = {fe_sel_q ? fe_q : mode_hi_q,
                               mode_lo_q, 1'b0, rx_en_q,
                               tx_b8_q, rx_b8_q, ti_q, ri_q};
            `UEB_OFF_DATA:
                rdat_d[7:0] = rx_data_q;
            `UEB_OFF_STAT:
                rdat_d[7:0] = {dbuf_q, brk_rst_q, 1'b0, tx_busy,
                               fe_q, brk_q, 2'b00};
            `UEB_OFF_PWR:
                rdat_d[7:0] = {1'b0, fe_sel_q, 6'h00};
            `UEB_OFF_BAUD:
                rdat_d[15:0] = baud_q;
            `UEB_OFF_IRQ_ST:
                rdat_d[`UEB_IRQ_W-1:0] = ist_q;
            `UEB_OFF_IRQ_MSK:
                rdat_d[`UEB_IRQ_W-1:0] = imsk_q;
            `UEB_OFF_RST_SRC:
                rdat_d[0] = boot_q;
            default:
                rdat_d = 32'h00000000;
        endcase
    end

    // bus slave with one wait state; registers; hardware sets win
    always @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            ack_o     <= 1'b0;
            dat_o     <= 32'h00000000;
            ist_q     <= {`UEB_IRQ_W{1'b0}};
            irq_o     <= 1'b0;
            mode_hi_q <= 1'b0;
            mode_lo_q <= 1'b0;
            rx_en_q   <= 1'b0;
            tx_b8_q   <= 1'b0;
            rx_b8_q   <= 1'b0;
            ti_q      <= 1'b0;
            ri_q      <= 1'b0;
            dbuf_q    <= 1'b0;
            brk_rst_q <= 1'b0;
            fe_q      <= 1'b0;
            brk_q     <= 1'b0;
            fe_sel_q  <= 1'b0;
            baud_q    <= `UEB_BAUD_RST;
            imsk_q    <= {`UEB_IRQ_W{1'b0}};
            rx_data_q <= 8'h00;
        end
        else
        begin
            ack_o <= req & ~ack_o;
            if (req & ~ack_o)
                dat_o <= rdat_d;
            if (ctrl_wr)
            begin
                // a zero in bit 7 clears the error flag when selected
                if (fe_sel_q)
                begin
                    if (!dat_i[`UEB_CTRL_MODE_HI])
                        fe_q <= 1'b0;
                end
                else
                    mode_hi_q <= dat_i[`UEB_CTRL_MODE_HI];
                mode_lo_q <= dat_i[`UEB_CTRL_MODE_LO];
                rx_en_q   <= dat_i[`UEB_CTRL_RX_EN];
                tx_b8_q   <= dat_i[`UEB_CTRL_TX_B8];
                rx_b8_q   <= dat_i[`UEB_CTRL_RX_B8];
                ti_q      <= dat_i[`UEB_CTRL_TX_INT];
                ri_q      <= dat_i[`UEB_CTRL_RX_INT];
            end
            if (stat_wr)
            begin
                dbuf_q    <= dat_i[`UEB_STAT_DBUF];
                brk_rst_q <= dat_i[`UEB_STAT_BRK_RST];
                if (!dat_i[`UEB_STAT_FE])
                    fe_q <= 1'b0;
                if (!dat_i[`UEB_STAT_BRK])
                    brk_q <= 1'b0;
            end
            if (wr && adr_i == `UEB_OFF_PWR)
                fe_sel_q <= dat_i[`UEB_PWR_FE_SEL];
            if (wr && adr_i == `UEB_OFF_BAUD && sel_i[1])
                baud_q <= dat_i[15:0];
            if (wr && adr_i == `UEB_OFF_IRQ_MSK)
                imsk_q <= dat_i[`UEB_IRQ_W-1:0];
            if (tx_ev)
                ti_q <= 1'b1;
            if (rx_done_q)
            begin
                ri_q      <= 1'b1;
                rx_data_q <= rx_byte_q;
                rx_b8_q   <= rx_b8_new_q;
            end
            if (rx_done_q && rx_fe_q)
                fe_q <= 1'b1;
            if (brk_ev_q)
                brk_q <= 1'b1;
            // sticky interrupt status, cleared by reading it
            if (rd && adr_i == `UEB_OFF_IRQ_ST)
                ist_q <= {`UEB_IRQ_W{1'b0}};
            if (rx_done_q)
                ist_q[`UEB_IRQ_RX] <= 1'b1;
            if (tx_ev)
                ist_q[`UEB_IRQ_TX] <= 1'b1;
            if (rx_done_q && rx_fe_q)
                ist_q[`UEB_IRQ_FE] <= 1'b1;
            if (brk_ev_q)
                ist_q[`UEB_IRQ_BRK] <= 1'b1;
            irq_o <= |(ist_q & imsk_q);
        end
    end

    // break reset: boot flag survives system reset, cleared by por or by writing zero to reset source bit 0
    always @(posedge clk_i)
    begin
        if (por_i)
        begin
            boot_q         <= 1'b0;
            device_reset_o <= 1'b0;
        end
        else
        begin
            device_reset_o <= brk_ev_q & brk_rst_q & ~rst_i;
            if (wr && adr_i == `UEB_OFF_RST_SRC && !dat_i[0])
                boot_q <= 1'b0;
            if (brk_ev_q && brk_rst_q && !rst_i)
                boot_q <= 1'b1;
        end
    end

    // sixteen baud ticks per bit, line synchroniser, break counter;
    // break counting runs whether or not the receiver is enabled
    always @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            bcnt_q    <= 16'h0000;
            tick_q    <= 1'b0;
            rx_s1_q   <= 1'b1;
            rx_s2_q   <= 1'b1;
            brk_cnt_q <= 8'h00;
            brk_arm_q <= 1'b1;
            brk_ev_q  <= 1'b0;
        end
        else
        begin
            tick_q <= 1'b0;
            if (bcnt_q >= baud_q)
            begin
                bcnt_q <= 16'h0000;
                tick_q <= 1'b1;
            end
            else
                bcnt_q <= bcnt_q + 16'h0001;
            rx_s1_q  <= rxd_i;
            rx_s2_q  <= rx_s1_q;
            brk_ev_q <= 1'b0;
            if (rx_s2_q)
            begin
                brk_cnt_q <= 8'h00;
                brk_arm_q <= 1'b1;
            end
            else if (tick_q && brk_arm_q)
            begin
                if (brk_cnt_q == `UEB_BRK_TICKS - 8'd1)
                begin
                    brk_ev_q  <= 1'b1;
                    brk_arm_q <= 1'b0;
                    brk_cnt_q <= 8'h00;
                end
                else
                    brk_cnt_q <= brk_cnt_q + 8'h01;
            end
        end
    end

    // receiver, samples at mid bit
    always @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            rx_st_q     <= RX_IDLE;
            rx_sub_q    <= 4'h0;
            rx_bit_q    <= 4'h0;
            rx_sh_q     <= 9'h000;
            rx_done_q   <= 1'b0;
            rx_fe_q     <= 1'b0;
            rx_byte_q   <= 8'h00;
            rx_b8_new_q <= 1'b0;
        end
        else
        begin
            rx_done_q <= 1'b0;
            case (rx_st_q)
                RX_IDLE:
                begin
                    rx_sub_q <= 4'h0;
                    if (rx_en_q && !rx_s2_q)
                        rx_st_q <= RX_START;
                end
                RX_START:
                begin
                    if (tick_q)
                    begin
                        rx_sub_q <= rx_sub_q + 4'h1;
                        if (rx_sub_q == `UEB_OVS_MID)
                        begin
                            rx_sub_q <= 4'h0;
                            rx_bit_q <= 4'h0;
                            // glitch, not a start bit
                            rx_st_q  <= rx_s2_q ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA:
                begin
                    if (tick_q)
                    begin
                        rx_sub_q <= rx_sub_q + 4'h1;
                        if (rx_sub_q == `UEB_OVS_LAST)
                        begin
                            rx_bit_q <= rx_bit_q + 4'h1;
                            if (rx_bit_q == rx_last_w)
                            begin
                                rx_done_q   <= 1'b1;
                                rx_fe_q     <= ~rx_s2_q;
                                rx_byte_q   <= nine_w ? rx_sh_q[7:0] : rx_sh_q[8:1];
                                // eight-bit mode keeps stop bit
                                rx_b8_new_q <= nine_w ? rx_sh_q[8]
                                                      : rx_s2_q;
                                rx_st_q     <= RX_IDLE;
                            end
                            else
                                rx_sh_q <= {rx_s2_q, rx_sh_q[8:1]};
                        end
                    end
                end
                default:
                    rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // mode 0 is run as an eight-bit async frame; left to software
    ueb_tx u_tx (
        .clk_i  (clk_i),
        .rst_i  (sys_rst),
        .tick_i (tick_q),
        .load_i (wr && adr_i == `UEB_OFF_DATA),
        .data_i (dat_i[7:0]),
        .ninth_i(tx_b8_q),
        .nine_i (nine_w),
        .dbuf_i (dbuf_q),
        .txd_o  (txd_o),
        .done_o (tx_done),
        .free_o (tx_free),
        .busy_o (tx_busy)
    );
endmodule

//--- verification/ueb_properties.sv
// port-level checker for the serial port block
// assumes baud register 0 (16 clocks per bit) whenever txd_o is busy
`include "ueb_map.vh"
module ueb_properties (
    // clock and resets
    input wire        clk_i,
    input wire        rst_i,
    input wire        por_i,
    // bus
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    // serial and system
    input wire        rxd_i,
    input wire        txd_o,
    input wire        device_reset_o,
    input wire        boot_from_vector_o,
    input wire        in_system_programming_mode_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);
    logic [8:0] low_run_q;
    logic [8:0] rx_low_q;
    // run lengths; rx history kept across resets, the line is real
    always @(posedge clk_i)
    begin
        if (rst_i || por_i || txd_o)
            low_run_q <= 9'h000;
        else
            low_run_q <= low_run_q + 9'h001;
        if (rxd_i)
            rx_low_q <= 9'h000;
        else if (rx_low_q != 9'h1ff)
            rx_low_q <= rx_low_q + 9'h001;
    end
    a_ack_one_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing one cycle after request");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_has_req: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_read_width: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0
        && (adr_i == `UEB_OFF_BAUD || dat_o[15:8] == 8'h00))
        else $error("read data upper bits not zero");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i > 8'h1c
        |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_tx_bit_len: assert property ($rose(txd_o) |-> low_run_q[3:0] == 4'h0)
        else $error("low run on txd not whole bits");
    a_break_long_low: assert property ($rose(device_reset_o)
        |-> rx_low_q >= 9'h0b0)
        else $error("break reset before eleven low bits");
    a_reset_pulse: assert property (device_reset_o |=> !device_reset_o)
        else $error("device reset longer than one cycle");
    a_boot_follows: assert property (device_reset_o
        |-> ##[0:2] boot_from_vector_o)
        else $error("boot flag not set by break reset");
    a_isp_tracks: assert property (in_system_programming_mode_o
        == boot_from_vector_o)
        else $error("programming mode differs from boot flag");
endmodule
bind ueb_top ueb_properties ueb_properties_i (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
    .ack_o(ack_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .device_reset_o(device_reset_o),
    .boot_from_vector_o(boot_from_vector_o),
    .in_system_programming_mode_o(in_system_programming_mode_o)
);

//--- verification/ueb_partner.sv
// remote serial partner: frame sender, break maker, frame monitor
// assumes 16 clocks per bit and an idle-high line
module ueb_partner (
    // clock
    input  wire logic clk_i,
    // line
    input  wire logic txd_i,
    input  wire logic nine_i,
    output logic      rxd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT = 16;
    int         cyc_n;
    int         frames;
    int         gap;
    int         last_st;
    logic [7:0] got_byte;
    logic       got_ninth;
    logic       got_stop;
    initial rxd_o = 1'b1;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;
    // eleventh slot is idle high in eight-bit frames
    task automatic send(input logic [7:0] b, input logic n9, stp);
        logic [10:0] f;
        f = nine_i ? {stp, n9, b, 1'b0} : {1'b1, stp, b, 1'b0};
        for (int k = 0; k < 11; k++)
        begin
            rxd_o <= f[k];
            repeat (BIT) @(posedge clk_i);
        end
    endtask
    task automatic brk(input int bits);
        rxd_o <= 1'b0;
        repeat (bits * BIT) @(posedge clk_i);
        rxd_o <= 1'b1;
        repeat (BIT) @(posedge clk_i);
    endtask
    // sampled at mid bit, eight clocks into each bit period
    initial
    begin
        forever
        begin
            @(negedge txd_i);
            @(posedge clk_i);
            gap = cyc_n - last_st;
            last_st = cyc_n;
            repeat (BIT / 2 - 1) @(posedge clk_i);
            for (int k = 0; k < 8; k++)
            begin
                repeat (BIT) @(posedge clk_i);
                got_byte[k] = txd_i;
            end
            if (nine_i)
            begin
                repeat (BIT) @(posedge clk_i);
                got_ninth = txd_i;
            end
            repeat (BIT) @(posedge clk_i);
            got_stop = txd_i;
            frames++;
        end
    end
endmodule

//--- verification/uart_error_break_double_buffer_tb_top.sv
// self-checking bench for the serial port block
// assumes the partner model on the serial lines, baud register 0
`include "ueb_map.vh"
`define CHK(nm, e, g) \
begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
        failures++; \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
end
module uart_error_break_double_buffer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        por_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic        nine  = 1'b0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        rxd;
    logic        txd;
    logic        irq_o;
    logic        dev_rst;
    logic        boot;
    logic        in_system_programming_mode;
    int          failures;
    int          tests_run;
    int          resets;
    logic [31:0] q;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (dev_rst === 1'b1)
            resets <= resets + 1;
    ueb_top ueb_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd),
        .txd_o(txd), .irq_o(irq_o), .device_reset_o(dev_rst),
        .boot_from_vector_o(boot), .in_system_programming_mode_o(in_system_programming_mode)
    );
    ueb_partner ueb_partner_i (
        .clk_i(clk_i), .txd_i(txd), .nine_i(nine), .rxd_o(rxd)
    );
    task automatic results();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20)
        begin
            failures++;
            results();
        end
    endtask
    task automatic rc(input [7:0] a, input [31:0] m, e, input string nm);
        wb(1'b0, a, 32'h0);
        `CHK(nm, e, q & m)
    endtask
    // wait bounded; the bound covers several whole frames
    task automatic wait_frames(input int n);
        int k;
        k = 0;
        while (ueb_partner_i.frames < n && k++ < 5000)
            @(posedge clk_i);
        if (k >= 5000)
        begin
            failures++;
            results();
        end
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        rc(`UEB_OFF_BAUD, 32'hffffffff, 32'h40, "baud reset");
        rc(8'h20, 32'hffffffff, 32'h0, "unmapped read");
        wb(1'b1, `UEB_OFF_BAUD, 32'h0);
        wb(1'b1, `UEB_OFF_IRQ_MSK, 32'hf);
        wb(1'b1, `UEB_OFF_DATA, 32'ha5);
        wait_frames(1);
        `CHK("tx byte", 8'ha5, ueb_partner_i.got_byte)
        `CHK("tx stop", 1'b1, ueb_partner_i.got_stop)
        `CHK("tx irq early", 1'b0, irq_o)
        repeat (16) @(posedge clk_i);
        `CHK("tx irq line", 1'b1, irq_o)
        rc(`UEB_OFF_IRQ_ST, 32'h2, 32'h2, "tx irq status");
        $display("test tx single buffer done");
        wb(1'b1, `UEB_OFF_CTRL, 32'h10);
        ueb_partner_i.send(8'h3c, 1'b0, 1'b1);
        rc(`UEB_OFF_DATA, 32'hff, 32'h3c, "rx byte");
        rc(`UEB_OFF_CTRL, 32'h4, 32'h4, "stop in rx ninth");
        rc(`UEB_OFF_STAT, 32'h8, 32'h0, "no fe");
        wb(1'b1, `UEB_OFF_PWR, 32'h40);
        wb(1'b1, `UEB_OFF_IRQ_MSK, 32'h0);
        ueb_partner_i.send(8'h81, 1'b0, 1'b0);
        rc(`UEB_OFF_STAT, 32'h8, 32'h8, "fe in status");
        rc(`UEB_OFF_CTRL, 32'h80, 32'h80, "fe in control");
        `CHK("irq masked", 1'b0, irq_o)
        wb(1'b1, `UEB_OFF_PWR, 32'h0);
        rc(`UEB_OFF_CTRL, 32'h80, 32'h0, "mode bit back");
        rc(`UEB_OFF_STAT, 32'h8, 32'h8, "fe sticky");
        wb(1'b1, `UEB_OFF_STAT, 32'h0);
        rc(`UEB_OFF_STAT, 32'h8, 32'h0, "fe cleared");
        wb(1'b1, `UEB_OFF_IRQ_MSK, 32'hf);
        repeat (2) @(posedge clk_i);
        `CHK("irq unmasked", 1'b1, irq_o)
        rc(`UEB_OFF_IRQ_ST, 32'h5, 32'h5, "rx and fe irq");
        repeat (2) @(posedge clk_i);
        `CHK("irq cleared", 1'b0, irq_o)
        $display("test framing error done");
        nine <= 1'b1;
        wb(1'b1, `UEB_OFF_CTRL, 32'h98);
        ueb_partner_i.send(8'h5a, 1'b1, 1'b1);
        rc(`UEB_OFF_CTRL, 32'h4, 32'h4, "rx ninth one");
        ueb_partner_i.send(8'hc3, 1'b0, 1'b1);
        rc(`UEB_OFF_CTRL, 32'h4, 32'h0, "rx ninth zero");
        rc(`UEB_OFF_DATA, 32'hff, 32'hc3, "rx nine byte");
        wb(1'b1, `UEB_OFF_DATA, 32'h96);
        wait_frames(2);
        `CHK("tx ninth", 1'b1, ueb_partner_i.got_ninth)
        `CHK("tx nine byte", 8'h96, ueb_partner_i.got_byte)
        repeat (16) @(posedge clk_i);
        rc(`UEB_OFF_IRQ_ST, 32'h2, 32'h2, "tx irq at stop");
        $display("test nine bit done");
        wb(1'b1, `UEB_OFF_STAT, 32'h80);
        wb(1'b1, `UEB_OFF_DATA, 32'h11);
        repeat (4) @(posedge clk_i);
        rc(`UEB_OFF_IRQ_ST, 32'h2, 32'h2, "tx irq hold free");
        wb(1'b1, `UEB_OFF_CTRL, 32'h90);
        wb(1'b1, `UEB_OFF_DATA, 32'h22);
        wb(1'b1, `UEB_OFF_CTRL, 32'h98);
        wait_frames(3);
        `CHK("first ninth", 1'b1, ueb_partner_i.got_ninth)
        wait_frames(4);
        `CHK("second byte", 8'h22, ueb_partner_i.got_byte)
        `CHK("second ninth", 1'b0, ueb_partner_i.got_ninth)
        `CHK("one stop", 1'b1, ueb_partner_i.gap < 192)
        $display("test double buffer done");
        wb(1'b1, `UEB_OFF_STAT, 32'h40);
        ueb_partner_i.brk(10);
        `CHK("short low", 0, resets)
        ueb_partner_i.brk(12);
        `CHK("break reset", 1, resets)
        `CHK("boot flag", 1'b1, boot)
        `CHK("isp mode", 1'b1, in_system_programming_mode)
        rc(`UEB_OFF_STAT, 32'h4, 32'h4, "break flag");
        wb(1'b1, `UEB_OFF_STAT, 32'h40);
        rc(`UEB_OFF_STAT, 32'h4, 32'h0, "break cleared");
        ueb_partner_i.brk(12);
        `CHK("break rearmed", 2, resets)
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(`UEB_OFF_RST_SRC, 32'h1, 32'h1, "boot kept");
        por_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        por_i <= 1'b0;
        rc(`UEB_OFF_RST_SRC, 32'h1, 32'h0, "boot cleared");
        $display("test break done");
        results();
    end
endmodule
